// ### hdl/ssr_bus_front.sv
// Serial SRAM bus front end: select, bus width, mode register and pause
`include "ssr_consts.svh"
`default_nettype none
module ssr_bus_front (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic serial_in_or_line0_i,
	output logic serial_in_or_line0_o,
	output logic serial_in_or_line0_oe_o,
	input wire logic serial_out_or_line1_i,
	output logic serial_out_or_line1_o,
	output logic serial_out_or_line1_oe_o,
	input wire logic data_line2_i,
	output logic data_line2_o,
	output logic data_line2_oe_o,
	input wire logic pause_or_line3_i,
	output logic pause_or_line3_o,
	output logic pause_or_line3_oe_o,
	output ssr_pkg::ssr_status_t status_o
);
	import ssr_pkg::*;

	logic link_rst;
	logic armed_r;
	logic pause_now;
	logic link_run;
	ssr_state_t state_r;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic [2:0] step;
	logic byte_done;
	ssr_bus_mode_t bus_mode_r;
	logic [7:0] mode_reg_r;
	logic out_on_r;
	logic [7:0] out_sh_r;
	logic [7:0] out_rot;
	logic wide;
	logic quad;
	logic drive_ok;
	ssr_status_t status_async;

	// Deselect clears the whole sequence; mode state survives a select
	assign link_rst = rst_i | cs_n_i;

	// Set by the first rising chip select after reset; a select already
	// low at power-up therefore never starts a sequence
	always_ff @(posedge cs_n_i or posedge rst_i) begin
		if (rst_i) begin
			armed_r <= 1'b0;
		end else begin
			armed_r <= 1'b1;
		end
	end

	assign quad = (bus_mode_r == SSR_BUS_QUAD);
	assign wide = (bus_mode_r != SSR_BUS_SINGLE);

	// Pause pin level seen at a clock edge; only outside quad mode
	assign pause_now = ~quad & ~pause_or_line3_i;

	// A rising edge with pause low is dropped whole, sequence kept
	assign link_run = armed_r & ~cs_n_i & ~pause_now;

	// Next shift value and bit count for the active bus width
	always_comb begin
		step = `SSR_STEP_SINGLE;
		shift_nxt = {shift_r[6:0], serial_in_or_line0_i};
		case (bus_mode_r)
			SSR_BUS_DUAL: begin
				step = `SSR_STEP_DUAL;
				shift_nxt = {shift_r[5:0], serial_out_or_line1_i, serial_in_or_line0_i};
			end
			SSR_BUS_QUAD: begin
				step = `SSR_STEP_QUAD;
				shift_nxt = {shift_r[3:0], pause_or_line3_i, data_line2_i,
					serial_out_or_line1_i, serial_in_or_line0_i};
			end
			default: begin
				step = `SSR_STEP_SINGLE;
				shift_nxt = {shift_r[6:0], serial_in_or_line0_i};
			end
		endcase
		cnt_nxt = cnt_r + step;
		byte_done = (cnt_nxt == 3'h0);
	end

	// Command and data capture on the rising serial clock edge
	always_ff @(posedge sck_i or posedge link_rst) begin
		if (link_rst) begin
			state_r <= SSR_ST_CMD;
			shift_r <= 8'h00;
			cnt_r <= 3'h0;
		end else if (link_run) begin
			case (state_r)
				SSR_ST_CMD: begin
					shift_r <= shift_nxt;
					cnt_r <= cnt_nxt;
					if (byte_done) begin
						case (shift_nxt)
							`SSR_MODE_REGISTER_WRITE_CMD: state_r <= SSR_ST_MODE_WR;
							`SSR_MODE_REGISTER_READ_CMD: state_r <= SSR_ST_MODE_RD;
							default: state_r <= SSR_ST_SKIP;
						endcase
					end
				end
				SSR_ST_MODE_WR: begin
					shift_r <= shift_nxt;
					cnt_r <= cnt_nxt;
					if (byte_done) begin
						state_r <= SSR_ST_SKIP;
					end
				end
				SSR_ST_MODE_RD: begin
					state_r <= SSR_ST_MODE_RD;
				end
				SSR_ST_SKIP: begin
					state_r <= SSR_ST_SKIP;
				end
				default: begin
					state_r <= SSR_ST_SKIP;
				end
			endcase
		end
	end

	// Bus width changes only when a full command byte has arrived,
	// sampled at the width currently in force
	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			bus_mode_r <= SSR_BUS_SINGLE;
		end else if (link_run && state_r == SSR_ST_CMD && byte_done) begin
			case (shift_nxt)
				`SSR_ENTER_DUAL_CMD: bus_mode_r <= SSR_BUS_DUAL;
				`SSR_ENTER_QUAD_CMD: bus_mode_r <= SSR_BUS_QUAD;
				`SSR_BUS_MODE_RESET_CMD: bus_mode_r <= SSR_BUS_SINGLE;
				default: bus_mode_r <= bus_mode_r;
			endcase
		end
	end

	// Mode register; reserved bits always stored as zero
	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg_r <= `SSR_MODE_RESET;
		end else if (link_run && state_r == SSR_ST_MODE_WR && byte_done) begin
			mode_reg_r <= shift_nxt & `SSR_MODE_WRITE_MASK;
		end
	end

	// Rotate the read-back byte by the bus width; rotation repeats the
	// byte for as long as the master keeps clocking
	always_comb begin
		out_rot = {out_sh_r[6:0], out_sh_r[7]};
		case (bus_mode_r)
			SSR_BUS_DUAL: out_rot = {out_sh_r[5:0], out_sh_r[7:6]};
			SSR_BUS_QUAD: out_rot = {out_sh_r[3:0], out_sh_r[7:4]};
			default: out_rot = {out_sh_r[6:0], out_sh_r[7]};
		endcase
	end

	// Output phase runs on the falling edge; pause holds the shifter
	always_ff @(negedge sck_i or posedge link_rst) begin
		if (link_rst) begin
			out_on_r <= 1'b0;
			out_sh_r <= 8'h00;
		end else if (armed_r && state_r == SSR_ST_MODE_RD) begin
			if (!out_on_r) begin
				out_on_r <= 1'b1;
				out_sh_r <= mode_reg_r;
			end else if (!pause_now) begin
				out_sh_r <= out_rot;
			end
		end
	end

	// Pause gates the drivers directly, independent of the clock level;
	// this is the one pin path that is not purely registered
	assign drive_ok = out_on_r & (quad | pause_or_line3_i);

	// Line 1 carries the MSB in single and dual; in quad the nibble runs line 3 down to 0
	assign serial_out_or_line1_o = out_sh_r[quad ? 5 : 7];
	assign serial_out_or_line1_oe_o = drive_ok;

	// Line 0 drives only in wide modes
	assign serial_in_or_line0_o = out_sh_r[quad ? 4 : 6];
	assign serial_in_or_line0_oe_o = drive_ok & wide;

	// Lines 2 and 3 drive only in quad mode
	assign data_line2_o = out_sh_r[6];
	assign data_line2_oe_o = drive_ok & quad;
	assign pause_or_line3_o = out_sh_r[7];
	assign pause_or_line3_oe_o = drive_ok & quad;

	// Status toward the core; bus mode and mode bits change rarely
	// and the sync stage waits until the word is stable
	always_comb begin
		status_async.bus_mode = bus_mode_r;
		status_async.op_mode = mode_reg_r[`SSR_OPMODE_HI:`SSR_OPMODE_LO];
		status_async.active = armed_r & ~cs_n_i;
		status_async.paused = armed_r & ~cs_n_i & pause_now;
	end

	ssr_status_sync u_status_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i(status_async),
		.sync_o(status_o)
	);
endmodule
`default_nettype wire

// ### hdl/ssr_consts.svh
// Constants for the serial SRAM bus front end: commands, mode register fields, steps
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// Instruction bytes
`define SSR_ENTER_DUAL_CMD 8'h3b
`define SSR_ENTER_QUAD_CMD 8'h38
`define SSR_BUS_MODE_RESET_CMD 8'hff
`define SSR_MODE_REGISTER_WRITE_CMD 8'h01
`define SSR_MODE_REGISTER_READ_CMD 8'h05

// Mode register layout and reset value
`define SSR_OPMODE_HI 7
`define SSR_OPMODE_LO 6
`define SSR_OPMODE_BYTE 2'b00
`define SSR_OPMODE_PAGE 2'b10
`define SSR_OPMODE_SEQUENTIAL 2'b01
`define SSR_OPMODE_RESERVED 2'b11
`define SSR_MODE_WRITE_MASK 8'hc0
`define SSR_MODE_RESET 8'h40

// Bits moved per serial clock in each bus mode
`define SSR_STEP_SINGLE 3'h1
`define SSR_STEP_DUAL 3'h2
`define SSR_STEP_QUAD 3'h4

`endif

// ### hdl/ssr_pkg.sv
// Types shared by the serial SRAM bus front end
`default_nettype none
package ssr_pkg;
	// Bus width; single to dual and dual to quad differ in one bit
	typedef enum logic [1:0] {
		SSR_BUS_SINGLE = 2'b00,
		SSR_BUS_DUAL = 2'b01,
		SSR_BUS_QUAD = 2'b11
	} ssr_bus_mode_t;

	// Sequence state inside one select; command to write flips one bit, command to read flips both
	typedef enum logic [1:0] {
		SSR_ST_CMD = 2'b00,
		SSR_ST_MODE_WR = 2'b01,
		SSR_ST_MODE_RD = 2'b11,
		SSR_ST_SKIP = 2'b10
	} ssr_state_t;

	// Status handed from the link domain to the core domain
	typedef struct packed {
		ssr_bus_mode_t bus_mode;
		logic [1:0] op_mode;
		logic active;
		logic paused;
	} ssr_status_t;
endpackage
`default_nettype wire

// ### hdl/ssr_status_sync.sv
// Status word crossing from the serial clock domain into the core clock domain
`default_nettype none
module ssr_status_sync (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire ssr_pkg::ssr_status_t async_i,
	output ssr_pkg::ssr_status_t sync_o
);
	import ssr_pkg::*;

	ssr_status_t meta_r;
	ssr_status_t sync2_r;
	ssr_status_t sync3_r;

	// Three-flop chain; first stage feeds only the second
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end else begin
			meta_r <= async_i;
			sync2_r <= meta_r;
			sync3_r <= sync2_r;
		end
	end

	// Word taken only once two samples agree, so no torn multi-bit value
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_o <= '0;
		end else if (sync2_r == sync3_r) begin
			sync_o <= sync3_r;
		end
	end
endmodule
`default_nettype wire

// ### test/ssr_bus_front_monitor.sv
// Port-level assertions for the serial SRAM bus front end
`include "ssr_consts.svh"
`default_nettype none
module ssr_bus_front_monitor (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic pause_or_line3_i,
	input wire logic serial_in_or_line0_oe_o,
	input wire logic serial_out_or_line1_oe_o,
	input wire logic data_line2_oe_o,
	input wire logic pause_or_line3_oe_o,
	input wire ssr_pkg::ssr_status_t status_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import ssr_pkg::*;
	logic cs_high_seen_r;
	logic [3:0] oe;
	logic quad;
	// Enables gathered line 3 down to line 0
	assign oe = {pause_or_line3_oe_o, data_line2_oe_o, serial_out_or_line1_oe_o,
		serial_in_or_line0_oe_o};
	assign quad = status_o.bus_mode == SSR_BUS_QUAD;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Standby lasts until the select has been seen high once
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) cs_high_seen_r <= 1'b0;
		else if (cs_n_i) cs_high_seen_r <= 1'b1;
	end
	chk_standby_quiet: assert property (!cs_high_seen_r |-> oe == 4'h0)
		else $error("output enabled before first select");
	chk_desel_float: assert property (cs_n_i |-> oe == 4'h0)
		else $error("output enabled while deselected");
	chk_line2_quad: assert property (!quad |-> !oe[2])
		else $error("line 2 driven outside quad");
	chk_single_line0: assert property (status_o.bus_mode == SSR_BUS_SINGLE |-> !oe[0])
		else $error("line 0 driven in single mode");
	chk_line3_pause: assert property (!quad |-> !oe[3])
		else $error("pause pin driven outside quad");
	chk_pause_float: assert property (!quad && !pause_or_line3_i |-> !oe[1])
		else $error("line 1 driven while paused");
	chk_dual_pair: assert property (status_o.bus_mode == SSR_BUS_DUAL |-> oe == 4'h0 || oe == 4'h3)
		else $error("dual lines not driven together");
	chk_quad_group: assert property (quad |-> oe == 4'h0 || oe == 4'hf)
		else $error("quad lines not driven together");
	chk_mode_default: assert property ($fell(rst_i) |-> ##[1:10]
		status_o.op_mode == `SSR_OPMODE_SEQUENTIAL)
		else $error("mode field not sequential after reset");
endmodule
bind ssr_bus_front ssr_bus_front_monitor ssr_bus_front_monitor_inst (.*);
`default_nettype wire

// ### test/ssr_master_model.sv
// Bus master model for the serial SRAM front end, lines pulled up
`default_nettype none
module ssr_master_model (
	input wire logic [3:0] dev_o_i,
	input wire logic [3:0] dev_oe_i,
	output logic sck_o,
	output logic cs_n_o,
	output logic [3:0] line_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] drv, en;
	logic pause_n;
	int w;
	// Selected from power-up so that standby is probed; pause kept high
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b0;
		drv = 4'h0;
		en = 4'h0;
		pause_n = 1'b1;
		w = 1;
	end
	// Released lines read as the pull-up level, not the last value
	always_comb begin
		for (int i = 0; i < 3; i++) line_o[i] = dev_oe_i[i] ? dev_o_i[i] : (en[i] ? drv[i] : 1'b1);
		line_o[3] = dev_oe_i[3] ? dev_o_i[3] : (w != 4 ? pause_n : (en[3] ? drv[3] : 1'b1));
	end
	// One byte at the current width, MSB first, clock only within the frame
	task automatic xfer(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
		for (int k = 8 - w; k >= 0; k -= w) begin
			#2;
			// Paused: clock and data toggle and must be ignored, select held
			while (!pause_n) begin
				drv = ~drv;
				#5.5 sck_o = 1'b1;
				#7.5 sck_o = 1'b0;
				#2;
			end
			for (int j = 0; j < w; j++) drv[j] = tx[k+j];
			en = drive ? 4'((1 << w) - 1) : 4'h0;
			#5.5 sck_o = 1'b1;
			for (int j = 0; j < w; j++) rx[k+j] = line_o[w == 1 ? 1 : j];
			#7.5 sck_o = 1'b0;
		end
		en = 4'h0;
	endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the serial SRAM bus front end
`include "ssr_consts.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ssr_pkg::*;
	logic core_clk, rst, sck, cs_n;
	logic [3:0] dev_o, dev_oe, line;
	logic [7:0] rx;
	ssr_status_t status;
	int n_fail, compares;
	ssr_bus_front ssr_bus_front_inst (.core_clk_i(core_clk), .rst_i(rst), .sck_i(sck),
		.cs_n_i(cs_n), .serial_in_or_line0_i(line[0]), .serial_in_or_line0_o(dev_o[0]),
		.serial_in_or_line0_oe_o(dev_oe[0]), .serial_out_or_line1_i(line[1]),
		.serial_out_or_line1_o(dev_o[1]), .serial_out_or_line1_oe_o(dev_oe[1]),
		.data_line2_i(line[2]), .data_line2_o(dev_o[2]), .data_line2_oe_o(dev_oe[2]),
		.pause_or_line3_i(line[3]), .pause_or_line3_o(dev_o[3]),
		.pause_or_line3_oe_o(dev_oe[3]), .status_o(status));
	ssr_master_model ssr_master_model_inst (.dev_o_i(dev_o), .dev_oe_i(dev_oe), .sck_o(sck),
		.cs_n_o(cs_n), .line_o(line));
	// Core clock; the serial clock comes from the master model
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic bx(input logic [7:0] tx, input logic drive);
		ssr_master_model_inst.xfer(tx, drive, rx);
	endtask
	task automatic sel(input logic v);
		ssr_master_model_inst.cs_n_o = v;
		#20;
	endtask
	// Status crosses into the core clock, so give it time to settle
	task automatic settle();
		repeat (10) @(posedge core_clk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] c, input int nw);
		sel(1'b0);
		bx(c, 1'b1);
		sel(1'b1);
		ssr_master_model_inst.w = nw;
		settle();
	endtask
	task automatic rdm();
		sel(1'b0);
		bx(`SSR_MODE_REGISTER_READ_CMD, 1'b1);
		bx(8'h00, 1'b0);
		sel(1'b1);
	endtask
	// Select low since power-up: a write must not land
	task automatic s_standby();
		bx(`SSR_MODE_REGISTER_WRITE_CMD, 1'b1);
		bx(8'h00, 1'b1);
		sel(1'b1);
		settle();
		check(8'(status.op_mode), 8'(`SSR_OPMODE_SEQUENTIAL));
	endtask
	// Every mode code, written with the low bits set
	task automatic s_modes();
		// Last code leaves bits 7 and 6 set, the c0 that the later reads in s_pause and s_wide expect
		logic [7:0] codes [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
		foreach (codes[i]) begin
			cmd(`SSR_MODE_REGISTER_WRITE_CMD, 1);
			sel(1'b0);
			bx(`SSR_MODE_REGISTER_WRITE_CMD, 1'b1);
			bx(codes[i] | 8'h3f, 1'b1);
			sel(1'b1);
			rdm();
			check(rx, codes[i]);
			settle();
			check(8'(status.op_mode), 8'(codes[i][7:6]));
		end
	endtask
	// Pause in mid-read with clocks running meanwhile
	task automatic s_pause();
		sel(1'b0);
		bx(`SSR_MODE_REGISTER_READ_CMD, 1'b1);
		fork
			bx(8'h00, 1'b0);
			begin
				#1 ssr_master_model_inst.pause_n = 1'b0;
				#1 check(8'(dev_oe[1]), 8'h00);
				#44 ssr_master_model_inst.pause_n = 1'b1;
				#1 check(8'(dev_oe[1]), 8'h01);
			end
		join
		sel(1'b1);
		check(rx, 8'hc0);
	endtask
	task automatic s_wide(input logic [7:0] c, input int nw, input ssr_bus_mode_t m);
		cmd(c, nw);
		check(8'(status.bus_mode), 8'(m));
		rdm();
		check(rx, 8'hc0);
		cmd(`SSR_BUS_MODE_RESET_CMD, 1);
		check(8'(status.bus_mode), 8'(SSR_BUS_SINGLE));
		rdm();
		check(rx, 8'hc0);
	endtask
	initial begin
		rst = 1'b1;
		repeat (12) @(posedge core_clk);
		#1 rst = 1'b0;
		settle();
		s_standby();
		s_modes();
		s_pause();
		s_wide(`SSR_ENTER_DUAL_CMD, 2, SSR_BUS_DUAL);
		s_wide(`SSR_ENTER_QUAD_CMD, 4, SSR_BUS_QUAD);
		report_and_stop();
	end
	// Watchdog far beyond the expected run of a few microseconds
	initial begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire
